// file: design/pgp_port_g.sv
`timescale 1ns/1ps
`include "pgp_consts.svh"
// How it works
// - Five pins, each output or input.
// - Direction 0 drives latch, 1 reads pin.
// - Digital inputs pass a Schmitt filter.
// - Open-drain bits for capture and serial outputs.
// - Peripherals may force pin output or input.
// - Overrides never alter the direction register.
// - Capture outputs beat latch; inputs feed capture.
// - Serial2 on pins 1 and 2.
// - Pins 1-4 analog at reset, digital when cleared.
// - Pin 4 clock output, timer inputs, direction ignored.
// - Enhanced PWM outputs tri-state during shutdown; capture unit 4 and 5 PWM do not.
// - Bit 5 exists only without master clear.
// - Unimplemented bits read as zero.

// ****************************************************************
// Schmitt-style input filter
// ****************************************************************
module pgp_schmitt_filter #(
  parameter int W = 6,
  parameter int SAMPLES = `PGP_SCHMITT_SAMPLES
) (
  input wire logic clk, // core clock
  input wire logic arst_n, // asynchronous reset
  input wire logic [W-1:0] rawIn, // pad levels
  output logic [W-1:0] level_ff // filtered levels
);
  logic [W-1:0] hist_ff [SAMPLES];

  if (SAMPLES < 2) begin : g_bad_samples
    $error("SAMPLES must be at least 2");
  end

  // A level flips only after every sample agrees, which gives hysteresis.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < SAMPLES; s++) hist_ff[s] <= '0;
    end else begin
      hist_ff[0] <= rawIn;
      for (int s = 1; s < SAMPLES; s++) hist_ff[s] <= hist_ff[s-1];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_ff <= '0;
    end else begin
      for (int b = 0; b < W; b++) begin
        logic ones;
        logic zeros;
        ones = 1'h1;
        zeros = 1'h1;
        for (int s = 0; s < SAMPLES; s++) begin
          ones = ones & hist_ff[s][b];
          zeros = zeros & ~hist_ff[s][b];
        end
        if (ones) level_ff[b] <= 1'h1;
        else if (zeros) level_ff[b] <= 1'h0;
      end
    end
  end

  flip_needs_agree_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(level_ff[0]) |-> $past(hist_ff[0][0]) == level_ff[0]
      && $past(hist_ff[1][0]) == level_ff[0])
    else $error("filter flipped without agreement");
endmodule

// ****************************************************************
// Port G pin logic
// ****************************************************************
module pgp_port_g import pgp_pkg::*; #(
  parameter int NPINS = 5
) (
  input wire logic ref_clk, // core clock
  input wire logic arst_n, // asynchronous reset
  input wire logic [2:0] regAddr, // register offset
  input wire logic [7:0] regWrData, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdData_ff, // read data, cycle after strobe
  input wire logic [5:0] padIn, // pad levels, bit 5 is the reset pin
  output logic [4:0] padOut_ff, // pad output levels
  output logic [4:0] padOe_ff, // pad output enables
  input wire logic masterClearPinEnable, // strap: 1 = bit 5 is master clear
  input wire logic ecc3OutEn, // enhanced capture 3 compare/PWM active
  input wire logic ecc3Out, // enhanced capture 3 output A
  input wire logic epwm3Shutdown, // enhanced PWM 3 shutdown tri-state
  input wire logic serial2TxEn, // serial 2 transmit or sync clock drive
  input wire logic serial2TxData, // serial 2 transmit or sync clock
  input wire logic serial2SyncDataOutEn, // serial 2 sync data drive
  input wire logic serial2SyncData, // serial 2 sync data out
  input wire logic serial2RxEn, // serial 2 receive active
  input wire logic comparator3ResultEn, // comparator 3 output enable
  input wire logic comparator3Result, // comparator 3 result
  input wire logic ccp4OutEn, // capture unit 4 compare/PWM active
  input wire logic ccp4Out, // capture unit 4 output
  input wire logic epwm3OutDEn, // enhanced PWM 3 output D active
  input wire logic epwm3OutD, // enhanced PWM 3 output D
  input wire logic rtccOutEn, // real-time clock output active
  input wire logic rtccOut, // real-time clock output
  input wire logic ccp5OutEn, // capture unit 5 compare/PWM active
  input wire logic ccp5Out, // capture unit 5 output
  input wire logic epwm1OutDEn, // enhanced PWM 1 output D active
  input wire logic epwm1OutD, // enhanced PWM 1 output D
  input wire logic epwm1Shutdown, // enhanced PWM 1 shutdown tri-state
  output logic ecc3CaptureIn_ff, // pin 0 to capture 3
  output logic serial2ClockIn_ff, // pin 1 to serial 2 clock in
  output logic serial2RxIn_ff, // pin 2 to serial 2 receive/data
  output logic ccp4CaptureIn_ff, // pin 3 to capture 4
  output logic ccp5CaptureIn_ff, // pin 4 to capture 5
  output logic timer7ClockIn_ff, // pin 4 to timer 7 clock
  output logic timer5GateIn_ff, // pin 4 to timer 5 gate
  output logic [4:0] analogPinSel_ff // pins routed to the analog mux
);
  if (NPINS != 5) begin : g_bad_npins
    $error("NPINS must be 5");
  end

  logic [4:0] latch_ff, dir_ff, anaPin, forceIn, forceOut, ovrEn, ovrData, odEn, shutHiz;
  logic [7:0] ansel_ff, odA_ff, odB_ff, odC_ff, nxt_rdData, pinRead;
  logic mclrEn_ff, strapTaken_ff;
  logic [5:0] level;

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  // Taken once after release so the reset value stays a constant.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strapTaken_ff <= 1'h0;
      mclrEn_ff <= 1'h1;
    end else if (!strapTaken_ff) begin
      strapTaken_ff <= 1'h1;
      mclrEn_ff <= masterClearPinEnable;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_ff <= `PGP_RST_LATCH;
    end else if (regWr && (regAddr == REG_PIN_LEVELS || regAddr == REG_OUT_LATCH)) begin
      latch_ff <= regWrData[4:0];
    end
  end

  // Only software writes land here; overrides act on the pad path.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_ff <= `PGP_RST_DIR;
    end else if (regWr && regAddr == REG_DIRECTION) begin
      dir_ff <= regWrData[4:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ansel_ff <= `PGP_RST_ANALOG;
    end else if (regWr && regAddr == REG_ANALOG_SEL) begin
      ansel_ff <= regWrData;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      odA_ff <= `PGP_RST_OD;
      odB_ff <= `PGP_RST_OD;
      odC_ff <= `PGP_RST_OD;
    end else if (regWr) begin
      if (regAddr == REG_OD_A) odA_ff <= regWrData & `PGP_MASK_OD_A;
      if (regAddr == REG_OD_B) odB_ff <= regWrData;
      if (regAddr == REG_OD_C) odC_ff <= regWrData & `PGP_MASK_OD_C;
    end
  end

  // ****************************************************************
  // Input path
  // ****************************************************************
  pgp_schmitt_filter #(
    .W(6),
    .SAMPLES(`PGP_SCHMITT_SAMPLES)
  ) u_filter (
    .clk(ref_clk),
    .arst_n(arst_n),
    .rawIn(padIn),
    .level_ff(level)
  );

  always_comb begin
    anaPin = 5'h00;
    anaPin[1] = ansel_ff[`PGP_ANSEL_PIN1];
    anaPin[2] = ansel_ff[`PGP_ANSEL_PIN2];
    anaPin[3] = ansel_ff[`PGP_ANSEL_PIN3];
    anaPin[4] = ansel_ff[`PGP_ANSEL_PIN4];
    pinRead = 8'h00;
    pinRead[4:0] = level[4:0] & ~anaPin;
    pinRead[`PGP_BIT5] = ~mclrEn_ff & level[5];
  end

  // Capture inputs see the pin only while the pin is an input.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ecc3CaptureIn_ff <= 1'h0;
      ccp4CaptureIn_ff <= 1'h0;
      ccp5CaptureIn_ff <= 1'h0;
      serial2ClockIn_ff <= 1'h0;
      serial2RxIn_ff <= 1'h0;
      timer7ClockIn_ff <= 1'h0;
      timer5GateIn_ff <= 1'h0;
      analogPinSel_ff <= 5'h00;
    end else begin
      ecc3CaptureIn_ff <= dir_ff[0] & level[0];
      ccp4CaptureIn_ff <= dir_ff[3] & level[3];
      ccp5CaptureIn_ff <= dir_ff[4] & level[4];
      serial2ClockIn_ff <= level[1];
      serial2RxIn_ff <= level[2];
      timer7ClockIn_ff <= level[4];
      timer5GateIn_ff <= level[4];
      analogPinSel_ff <= anaPin;
    end
  end

  // ****************************************************************
  // Peripheral overrides
  // ****************************************************************
  always_comb begin
    {forceIn, forceOut, ovrEn, ovrData, odEn, shutHiz} = 30'h00000000;
    ovrEn[0] = ecc3OutEn;
    ovrData[0] = ecc3Out;
    odEn[0] = odB_ff[`PGP_OD_B_CCP3];
    shutHiz[0] = epwm3Shutdown;
    if (serial2TxEn) begin
      forceOut[1] = 1'h1;
      ovrData[1] = serial2TxData;
      odEn[1] = odC_ff[`PGP_OD_C_SER2];
    end else if (comparator3ResultEn) begin
      forceOut[1] = 1'h1;
      ovrData[1] = comparator3Result;
    end
    forceOut[2] = serial2SyncDataOutEn;
    ovrData[2] = serial2SyncData;
    odEn[2] = odC_ff[`PGP_OD_C_SER2];
    forceIn[2] = serial2RxEn & ~serial2SyncDataOutEn;
    if (ccp4OutEn) begin
      ovrEn[3] = 1'h1;
      ovrData[3] = ccp4Out;
      odEn[3] = odB_ff[`PGP_OD_B_CAPTURE_UNIT_4];
    end else if (epwm3OutDEn) begin
      ovrEn[3] = 1'h1;
      ovrData[3] = epwm3OutD;
      odEn[3] = odB_ff[`PGP_OD_B_CCP3];
      shutHiz[3] = epwm3Shutdown;
    end
    if (rtccOutEn) begin
      forceOut[4] = 1'h1;
      ovrData[4] = rtccOut;
    end else if (ccp5OutEn) begin
      ovrEn[4] = 1'h1;
      ovrData[4] = ccp5Out;
      odEn[4] = odB_ff[`PGP_OD_B_CAPTURE_UNIT_5];
    end else if (epwm1OutDEn) begin
      ovrEn[4] = 1'h1;
      ovrData[4] = epwm1OutD;
      odEn[4] = odA_ff[`PGP_OD_A_CCP1];
      shutHiz[4] = epwm1Shutdown;
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Analog selection leaves the drivers alone, so a pin may drive while analog.
  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    pgp_pin_cell u_cell (
      .clk(ref_clk),
      .arst_n(arst_n),
      .latchBit(latch_ff[p]),
      .dirBit(dir_ff[p]),
      .forceIn(forceIn[p]),
      .forceOut(forceOut[p]),
      .ovrEn(ovrEn[p]),
      .ovrData(ovrData[p]),
      .odEn(odEn[p]),
      .shutHiz(shutHiz[p]),
      .padOut_ff(padOut_ff[p]),
      .padOe_ff(padOe_ff[p])
    );
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_comb begin
    case (regAddr)
      REG_PIN_LEVELS: nxt_rdData = pinRead;
      REG_OUT_LATCH: nxt_rdData = {3'h0, latch_ff};
      REG_DIRECTION: nxt_rdData = {3'h0, dir_ff};
      REG_ANALOG_SEL: nxt_rdData = ansel_ff;
      REG_OD_A: nxt_rdData = odA_ff;
      REG_OD_B: nxt_rdData = odB_ff;
      REG_OD_C: nxt_rdData = odC_ff;
      default: nxt_rdData = 8'h00;
    endcase
  end

  // Data stand for one cycle only, then return to zero.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData_ff <= 8'h00;
    end else begin
      regRdData_ff <= regRd ? nxt_rdData : 8'h00;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_dirRead;
    regRd && regAddr == REG_DIRECTION;
  endsequence
  sequence s_pinRead;
    regRd && regAddr == REG_PIN_LEVELS;
  endsequence
  sequence s_latchWrite;
    regWr && regAddr == REG_OUT_LATCH && !dir_ff[0] && !ecc3OutEn;
  endsequence

  direction_readback_a: assert property (s_dirRead |=> regRdData_ff == {3'h0, $past(dir_ff)})
    else $error("direction readback wrong");
  direction_holds_a: assert property (!regWr |=> $stable(dir_ff))
    else $error("direction changed without write");
  od_unimpl_zero_a: assert property (regRd && regAddr == REG_OD_C |=>
    (regRdData_ff & ~`PGP_MASK_OD_C) == 8'h00)
    else $error("unimplemented bits read nonzero");
  latch_to_pad_a: assert property (s_latchWrite ##1 (!dir_ff[0] && !ecc3OutEn) |=>
    padOe_ff[0] && padOut_ff[0] == $past(regWrData[0], 2))
    else $error("latch not driven on pin");
  input_no_drive_a: assert property (dir_ff[3] && !ccp4OutEn && !epwm3OutDEn |=> !padOe_ff[3])
    else $error("input pin driven");
  clock_out_pin_a: assert property (rtccOutEn |=> padOe_ff[4] && padOut_ff[4] == $past(rtccOut))
    else $error("clock output not on pin 4");
  cmp_out_pin_a: assert property (comparator3ResultEn && !serial2TxEn |=>
    padOe_ff[1] && padOut_ff[1] == $past(comparator3Result))
    else $error("comparator not on pin 1");
  open_drain_high_a: assert property (ecc3OutEn && !dir_ff[0] && !epwm3Shutdown
    && odB_ff[`PGP_OD_B_CCP3] && ecc3Out |=> !padOe_ff[0])
    else $error("open-drain drove high");
  pwm_shutdown_hiz_a: assert property (ecc3OutEn && !dir_ff[0] && epwm3Shutdown |=> !padOe_ff[0])
    else $error("shutdown pin not tri-stated");
  sync_data_out_a: assert property (serial2SyncDataOutEn && !odC_ff[`PGP_OD_C_SER2] |=>
    padOe_ff[2] && padOut_ff[2] == $past(serial2SyncData))
    else $error("sync data not driven");
  rx_forced_in_a: assert property (serial2RxEn && !serial2SyncDataOutEn |=> !padOe_ff[2])
    else $error("receive pin driven");
  analog_reads_zero_a: assert property (s_pinRead ##0 ansel_ff[`PGP_ANSEL_PIN1] |=>
    !regRdData_ff[1])
    else $error("analog pin read nonzero");
  bit5_hidden_a: assert property (s_pinRead ##0 mclrEn_ff |=> !regRdData_ff[`PGP_BIT5])
    else $error("bit 5 visible with master clear");
endmodule

// file: design/pgp_consts.svh
`ifndef PGP_CONSTS_SVH
`define PGP_CONSTS_SVH

// ****************************************************************
// Register word offsets on the register port
// ****************************************************************
`define PGP_OFF_PIN_LEVELS 3'h0
`define PGP_OFF_OUT_LATCH 3'h1
`define PGP_OFF_DIRECTION 3'h2
`define PGP_OFF_ANALOG_SEL 3'h3
`define PGP_OFF_OD_A 3'h4
`define PGP_OFF_OD_B 3'h5
`define PGP_OFF_OD_C 3'h6

// ****************************************************************
// Reset values and implemented-bit masks
// ****************************************************************
`define PGP_RST_LATCH 5'h00
`define PGP_RST_DIR 5'h1f
`define PGP_RST_ANALOG 8'hff
`define PGP_RST_OD 8'h00
`define PGP_MASK_OD_A 8'he1
`define PGP_MASK_OD_C 8'hc1

// ****************************************************************
// Field positions
// ****************************************************************
`define PGP_ANSEL_PIN1 3
`define PGP_ANSEL_PIN2 2
`define PGP_ANSEL_PIN3 1
`define PGP_ANSEL_PIN4 0
`define PGP_OD_B_CCP3 0
`define PGP_OD_B_CAPTURE_UNIT_4 1
`define PGP_OD_B_CAPTURE_UNIT_5 2
`define PGP_OD_A_CCP1 5
`define PGP_OD_C_SER2 7
`define PGP_BIT5 5

// ****************************************************************
// Timing counts
// ****************************************************************
`define PGP_SCHMITT_SAMPLES 2

`endif

// file: design/pgp_pkg.sv
package pgp_pkg;
  `include "pgp_consts.svh"

  typedef enum logic [2:0] {
    REG_PIN_LEVELS = `PGP_OFF_PIN_LEVELS,
    REG_OUT_LATCH = `PGP_OFF_OUT_LATCH,
    REG_DIRECTION = `PGP_OFF_DIRECTION,
    REG_ANALOG_SEL = `PGP_OFF_ANALOG_SEL,
    REG_OD_A = `PGP_OFF_OD_A,
    REG_OD_B = `PGP_OFF_OD_B,
    REG_OD_C = `PGP_OFF_OD_C
  } pgp_reg_t;

  typedef enum logic [1:0] {
    SRC_INPUT = 2'h0,
    SRC_LATCH = 2'h1,
    SRC_PERIPH = 2'h2,
    SRC_HIZ = 2'h3
  } pgp_src_t;
endpackage

// file: design/pgp_pin_cell.sv
`timescale 1ns/1ps
module pgp_pin_cell import pgp_pkg::*; (
  input wire logic clk, // core clock
  input wire logic arst_n, // asynchronous reset
  input wire logic latchBit, // output latch bit
  input wire logic dirBit, // 1 = input
  input wire logic forceIn, // peripheral forces input
  input wire logic forceOut, // peripheral drives, direction ignored
  input wire logic ovrEn, // peripheral owns data while direction is output
  input wire logic ovrData, // peripheral data
  input wire logic odEn, // open-drain for peripheral data
  input wire logic shutHiz, // PWM shutdown tri-state request
  output logic padOut_ff, // pad output level
  output logic padOe_ff // pad output enable
);
  pgp_src_t src;
  logic periph;
  logic data;

  always_comb begin
    periph = forceOut | (ovrEn & ~dirBit);
    data = periph ? ovrData : latchBit;
    if (forceIn) begin
      src = SRC_INPUT;
    end else if (periph) begin
      src = (shutHiz & ~forceOut) ? SRC_HIZ : SRC_PERIPH;
    end else begin
      src = dirBit ? SRC_INPUT : SRC_LATCH;
    end
  end

  // Open-drain never drives a high; the pull-up outside supplies it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      padOe_ff <= 1'h0;
      padOut_ff <= 1'h0;
    end else begin
      case (src)
        SRC_LATCH: begin
          padOe_ff <= 1'h1;
          padOut_ff <= data;
        end
        SRC_PERIPH: begin
          padOe_ff <= ~(odEn & data);
          padOut_ff <= odEn ? 1'h0 : data;
        end
        default: begin
          padOe_ff <= 1'h0;
          padOut_ff <= 1'h0;
        end
      endcase
    end
  end
endmodule

// file: tb/pgp_board.sv
`timescale 1ns/1ps
// ********************
// Board circuitry on the port pins
// ********************
module pgp_board (
  input wire logic ref_clk, // core clock, paces the floating pattern
  input wire logic [4:0] padOut_ff, // device pad levels
  input wire logic [4:0] padOe_ff, // device drive enables
  input wire logic [5:0] extEn, // board drives the pin
  input wire logic [5:0] extVal, // level the board drives
  output logic [5:0] padIn // level seen on each pin
);
  logic [5:0] floatLvl = 6'h15;
  logic [5:0] devOe;
  logic [5:0] devOut;
  assign devOe = {1'b0, padOe_ff};
  assign devOut = {1'b0, padOut_ff};
  // A pin nobody drives has no pull here, so it must never look like a settled level.
  always @(posedge ref_clk) floatLvl <= ~floatLvl;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (devOe[i]) begin
        padIn[i] = devOut[i];
      end else if (extEn[i]) begin
        padIn[i] = extVal[i];
      end else begin
        padIn[i] = floatLvl[i];
      end
    end
  end
endmodule

// file: tb/pgp_port_g_tb.sv
`timescale 1ns/1ps
module pgp_port_g_tb;
  import pgp_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData_ff;
  logic [5:0] padIn;
  logic [4:0] padOut_ff, padOe_ff, anaSel, dirW, latW, eo, ev, aPins;
  logic mcEn = 1'b0;
  logic sd3 = 1'b0, sd1 = 1'b0, rxEn = 1'b0;
  logic [8:0] perEn = 9'h000, perDat = 9'h000;
  logic [5:0] extEn = 6'h00, extVal = 6'h00;
  wire [6:0] inTaps;
  logic [7:0] anaW;
  logic [8:0] caseEn [12] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040,
    9'h080, 9'h100, 9'h006, 9'h0c0, 9'h030};
  logic [7:0] rstVal [8] = '{8'h00, 8'h00, 8'h1f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  int n_errors = 0;
  int total_checks = 0;
  int seedDummy;
  always #2 ref_clk = ~ref_clk;

  pgp_port_g u_pgp_port_g (.ref_clk, .arst_n, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData_ff, .padIn, .padOut_ff, .padOe_ff, .masterClearPinEnable(mcEn),
    .ecc3OutEn(perEn[0]), .ecc3Out(perDat[0]), .epwm3Shutdown(sd3),
    .serial2TxEn(perEn[1]), .serial2TxData(perDat[1]),
    .comparator3ResultEn(perEn[2]), .comparator3Result(perDat[2]),
    .serial2SyncDataOutEn(perEn[3]), .serial2SyncData(perDat[3]), .serial2RxEn(rxEn),
    .ccp4OutEn(perEn[4]), .ccp4Out(perDat[4]), .epwm3OutDEn(perEn[5]), .epwm3OutD(perDat[5]),
    .rtccOutEn(perEn[6]), .rtccOut(perDat[6]), .ccp5OutEn(perEn[7]), .ccp5Out(perDat[7]),
    .epwm1OutDEn(perEn[8]), .epwm1OutD(perDat[8]), .epwm1Shutdown(sd1),
    .ecc3CaptureIn_ff(inTaps[0]), .serial2ClockIn_ff(inTaps[1]), .serial2RxIn_ff(inTaps[2]),
    .ccp4CaptureIn_ff(inTaps[3]), .ccp5CaptureIn_ff(inTaps[4]), .timer7ClockIn_ff(inTaps[5]),
    .timer5GateIn_ff(inTaps[6]), .analogPinSel_ff(anaSel));

  pgp_board u_pgp_board (.ref_clk, .padOut_ff, .padOe_ff, .extEn, .extVal, .padIn);

  // ********************
  // Bench tasks and expectations
  // ********************
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    check(regRdData_ff, exp);
  endtask

  task automatic doReset(input logic strap);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    mcEn <= strap;
    extEn <= 6'h00;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
  endtask

  function automatic logic [7:0] implMask(input logic [2:0] a);
    case (a)
      REG_OUT_LATCH, REG_DIRECTION: return 8'h1f;
      REG_ANALOG_SEL, REG_OD_B: return 8'hff;
      REG_OD_A: return 8'he1;
      REG_OD_C: return 8'hc1;
      default: return 8'h00;
    endcase
  endfunction

  // Analog select runs bit3 for pin 1 down to bit0 for pin 4.
  function automatic logic [4:0] anaPins(input logic [7:0] a);
    return {a[0], a[1], a[2], a[3], 1'b0};
  endfunction

  function automatic logic [9:0] expDrive(input logic [4:0] dir, input logic [4:0] lat,
    input logic [8:0] en, input logic [8:0] d);
    logic [4:0] oe;
    logic [4:0] ov;
    oe = ~dir;
    ov = lat;
    if (en[0] && !dir[0]) ov[0] = d[0];
    if (en[1] || en[2]) oe[1] = 1'b1;
    if (en[1] || en[2]) ov[1] = en[1] ? d[1] : d[2];
    if (en[3]) oe[2] = 1'b1;
    if (en[3]) ov[2] = d[3];
    if ((en[4] || en[5]) && !dir[3]) ov[3] = en[4] ? d[4] : d[5];
    if (en[6]) oe[4] = 1'b1;
    if (en[6]) ov[4] = d[6];
    else if ((en[7] || en[8]) && !dir[4]) ov[4] = en[7] ? d[7] : d[8];
    return {oe, ov};
  endfunction

  // ********************
  // Main sequence
  // ********************
  initial begin
    repeat (50000) @(posedge ref_clk);
    n_errors++;
    $display("Error at %0t: run did not finish", $time);
    print_verdict();
  end

  initial begin
    seedDummy = $urandom(32'h122129fc);
    doReset(1'b0);
    check({3'h0, padOe_ff}, 8'h00);
    for (int a = 1; a < 8; a++) rdChk(3'(a), rstVal[a]);
    for (int k = 0; k < 14; k++) begin
      anaW = 8'($urandom);
      wr(3'(k % 7 + 1), anaW);
      rdChk(3'(k % 7 + 1), anaW & implMask(3'(k % 7 + 1)));
    end
    $display("Test register access done");
    for (int a = 4; a < 7; a++) wr(3'(a), 8'h00);
    wr(REG_ANALOG_SEL, 8'hff);
    for (int c = 0; c < 24; c++) begin
      dirW = (c < 12) ? 5'($urandom) : (c[0] ? 5'h1f : 5'h00);
      latW = 5'($urandom);
      wr(REG_DIRECTION, {3'h0, dirW});
      wr(c[0] ? REG_OUT_LATCH : REG_PIN_LEVELS, {3'h0, latW});
      perEn <= caseEn[c % 12];
      perDat <= 9'($urandom);
      repeat (3) @(posedge ref_clk);
      {eo, ev} = expDrive(dirW, latW, caseEn[c % 12], perDat);
      check({3'h0, padOe_ff}, {3'h0, eo});
      check({3'h0, padOut_ff & eo}, {3'h0, ev & eo});
      rdChk(REG_DIRECTION, {3'h0, dirW});
    end
    $display("Test pin drive and overrides done");
    wr(REG_DIRECTION, 8'h00);
    wr(REG_OUT_LATCH, 8'h1f);
    perEn <= 9'h121;
    perDat <= 9'h1ff;
    sd3 <= 1'b1;
    sd1 <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check({3'h0, padOe_ff}, 8'h06);
    sd3 <= 1'b0;
    sd1 <= 1'b0;
    perEn <= 9'h093;
    wr(REG_OD_A, 8'h20);
    wr(REG_OD_B, 8'h07);
    wr(REG_OD_C, 8'h80);
    repeat (3) @(posedge ref_clk);
    check({3'h0, padOe_ff}, 8'h04);
    perDat <= 9'h000;
    repeat (3) @(posedge ref_clk);
    check({3'h0, padOe_ff}, 8'h1f);
    check({3'h0, padOut_ff}, 8'h04);
    perEn <= 9'h000;
    rxEn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check({3'h0, padOe_ff}, 8'h1b);
    rxEn <= 1'b0;
    $display("Test shutdown and open drain done");
    wr(REG_DIRECTION, 8'h1f);
    for (int k = 0; k < 8; k++) begin
      anaW = (k < 4) ? 8'h00 : 8'($urandom);
      wr(REG_ANALOG_SEL, anaW);
      extEn <= 6'h3f;
      extVal <= 6'($urandom);
      repeat (6) @(posedge ref_clk);
      if (k == 2) begin
        extVal <= extVal ^ 6'h1f;
        @(posedge ref_clk);
        extVal <= extVal ^ 6'h1f;
        repeat (6) @(posedge ref_clk);
      end
      aPins = anaPins(anaW);
      rdChk(REG_PIN_LEVELS, {2'h0, extVal & ~{1'b0, aPins}});
      check({1'b0, inTaps}, {1'b0, {3{extVal[4]}}, extVal[3:0]});
      check({3'h0, anaSel}, {3'h0, aPins});
    end
    $display("Test pin sensing done");
    doReset(1'b1);
    @(posedge ref_clk);
    extEn <= 6'h3f;
    extVal <= 6'h20;
    wr(REG_ANALOG_SEL, 8'h00);
    repeat (6) @(posedge ref_clk);
    rdChk(REG_PIN_LEVELS, 8'h00);
    $display("Test master clear strap done");
    print_verdict();
  end
endmodule
